/* File: twd_defines.vh */
// constants of the thermal watchdog control block
// Overview of operation
// R1: five-bit sampling period field at pointer four
// R2: upper three period bits are ignored
// R3: conversion starts every field times 100 ms
// R4: period field zero behaves as one
// R5: period field resets to one
// R6: conversion lasts 28 ms, then idle
// R7: config bit 2 selects output polarity
// R8: config bit 1 selects interrupt mode
// R9: comparator output follows thresholds, ignores reads
// R10: interrupt output latches until any read
// R11: host keeps high threshold above low
// R12: trips judged at conversion end, queued
// R13: config bits 4:3 give 1,2,4,6 faults
// R14: config bit 0 selects shutdown
// R15: shutdown stops conversions, bus keeps working
// R16: shutdown clears output in interrupt mode
// R17: reset defaults: normal, comparator, 80/75, pointer 0
// R18: each byte is nine clock pulses
// R19: repeated start begins the read command
// R20: device drives acknowledge low
// R21: host acknowledge asks for second byte
// R22: single upper byte read ends cleanly
// R23: compare only upper nine temperature bits
// R24: thresholds held as nine-bit values
// R25: temperature held as eleven bits
// R26: ticks from internal free-running time base
`ifndef TWD_DEFINES_VH
`define TWD_DEFINES_VH
// ===========================================
// register pointers
`define TWD_PTR_TEMP    3'h0
`define TWD_PTR_CONFIG  3'h1
`define TWD_PTR_THYST   3'h2
`define TWD_PTR_TOS     3'h3
`define TWD_PTR_PERIOD  3'h4
// ===========================================
// config field positions
`define TWD_CFG_SHDN    0
`define TWD_CFG_MODE    1
`define TWD_CFG_POL     2
`define TWD_CFG_QLO     3
`define TWD_CFG_QHI     4
// ===========================================
// reset values
`define TWD_RST_CONFIG  5'h00
`define TWD_RST_PERIOD  5'h01
`define TWD_RST_TOS     9'h0A0
`define TWD_RST_THYST   9'h096
`define TWD_RST_PTR     3'h0
// ===========================================
// timing figures
`define TWD_CLK_KHZ     10000
`define TWD_TICK_MS     100
`define TWD_CONV_MS     28
`define TWD_TOUT_MS     30
`define TWD_BYTE_BITS   4'h8
`endif

/* File: twd_thermal_watchdog.v */
// thermal watchdog control: sampling timer, trip logic and two-wire slave
`timescale 1ns/100ps
`include "twd_defines.vh"

module twd_thermal_watchdog
#(
	parameter [6:0] DEV_ADDR     = 7'h30, // bus address, arbitrary value
	parameter       TICK_CYCLES  = `TWD_TICK_MS * `TWD_CLK_KHZ,
	parameter       CONV_CYCLES  = `TWD_CONV_MS * `TWD_CLK_KHZ,
	parameter       TOUT_CYCLES  = `TWD_TOUT_MS * `TWD_CLK_KHZ
)
(
	// clock and reset
	input  wire        mclk_in,
	input  wire        rstn_in,
	// two-wire bus pins
	input  wire        scl_in,
	input  wire        sda_in,
	output reg         sda_out,
	output reg         sda_oe_out,
	// converter front end
	input  wire [10:0] temp_data_in,
	output reg         conv_busy_out,
	// over-temperature pin
	output reg         overtemp_output_out,
	output reg         overtemp_output_oe_out
);

// ===========================================
// states
localparam [6:0] ST_IDLE = 7'h01;
localparam [6:0] ST_ADDR = 7'h02;
localparam [6:0] ST_AACK = 7'h04;
localparam [6:0] ST_WR   = 7'h08;
localparam [6:0] ST_WACK = 7'h10;
localparam [6:0] ST_RD   = 7'h20;
localparam [6:0] ST_RACK = 7'h40;

// ===========================================
// storage
reg  [4:0]  cfg;
reg  [4:0]  sample_period;
reg  [8:0]  tos;
reg  [8:0]  thyst;
reg  [10:0] temp;
reg  [2:0]  ptr;
reg  [23:0] tick_cnt;
reg  [4:0]  per_cnt;
reg  [23:0] conv_cnt;
reg  [2:0]  fcnt;
reg         hot;
reg         int_flag;
reg         sd_d;
reg         scl_s1;
reg         scl_s2;
reg         scl_d;
reg         sda_s1;
reg         sda_s2;
reg         sda_d;
reg  [6:0]  state;
reg  [3:0]  bitcnt;
reg  [7:0]  rx;
reg  [7:0]  tx;
reg         rw;
reg         first;
reg         widx;
reg         ridx;
reg         ack_ok;
reg         rd_pulse;
reg  [23:0] tout_cnt;

// ===========================================
// helpers
// byte presented for a read of pointer p, byte index i
function [7:0] rd_byte;
	input [2:0] p;
	input       i;
	begin
		case (p)
			`TWD_PTR_TEMP:   rd_byte = i ? {temp[2:0], 5'h00} : temp[10:3];
			`TWD_PTR_CONFIG: rd_byte = {3'h0, cfg};
			`TWD_PTR_THYST:  rd_byte = i ? {thyst[0], 7'h00} : thyst[8:1];
			`TWD_PTR_TOS:    rd_byte = i ? {tos[0], 7'h00} : tos[8:1];
			`TWD_PTR_PERIOD: rd_byte = {3'h0, sample_period};
			default:         rd_byte = 8'h00;
		endcase
	end
endfunction

// consecutive faults needed for a queue code
function [2:0] fault_need;
	input [1:0] code;
	begin
		case (code)
			2'h0:    fault_need = 3'h1;
			2'h1:    fault_need = 3'h2;
			2'h2:    fault_need = 3'h4;
			default: fault_need = 3'h6;
		endcase
	end
endfunction

wire [4:0] eff_period = (sample_period == 5'h00) ? 5'h01 : sample_period; // see R4
wire       shutdown   = cfg[`TWD_CFG_SHDN];
wire       tick       = (tick_cnt == TICK_CYCLES - 1);
wire       conv_done  = conv_busy_out & (conv_cnt == CONV_CYCLES - 1);
wire [8:0] temp9      = temp_data_in[10:2]; // see R23
wire       trip       = hot ? ($signed(temp9) < $signed(thyst))
                            : ($signed(temp9) > $signed(tos));
wire       q_full     = (fcnt + 3'h1 == fault_need(cfg[`TWD_CFG_QHI:`TWD_CFG_QLO])); // see R13
wire       trip_evt   = conv_done & trip & q_full;
wire       scl_rise   = scl_s2 & ~scl_d;
wire       scl_fall   = ~scl_s2 & scl_d;
wire       bus_start  = scl_s2 & scl_d & sda_d & ~sda_s2;
wire       bus_stop   = scl_s2 & scl_d & ~sda_d & sda_s2;
wire       act        = cfg[`TWD_CFG_MODE] ? int_flag : hot; // see R8
// bytes offered at the start of a read and after a host acknowledge
wire [7:0] rd_head    = rd_byte(ptr, 1'b0);
wire [7:0] rd_next    = rd_byte(ptr, ridx);

// ===========================================
// pin synchronisers, first stage feeds only the second
always @(posedge mclk_in or negedge rstn_in)
begin
	if (!rstn_in)
	begin
		scl_s1 <= 1'b1;
		scl_s2 <= 1'b1;
		scl_d  <= 1'b1;
		sda_s1 <= 1'b1;
		sda_s2 <= 1'b1;
		sda_d  <= 1'b1;
	end
	else
	begin
		scl_s1 <= scl_in;
		scl_s2 <= scl_s1;
		scl_d  <= scl_s2;
		sda_s1 <= sda_in;
		sda_s2 <= sda_s1;
		sda_d  <= sda_s2;
	end
end

// ===========================================
// free-running 100 ms time base, runs even in shutdown
always @(posedge mclk_in or negedge rstn_in)
begin
	if (!rstn_in)
		tick_cnt <= 24'h000000;
	else if (tick)
		tick_cnt <= 24'h000000; // see R26
	else
		tick_cnt <= tick_cnt + 24'h000001;
end

// ===========================================
// sampling period and conversion timer
// shutdown aborts a running conversion so no stale result lands later
always @(posedge mclk_in or negedge rstn_in)
begin
	if (!rstn_in)
	begin
		per_cnt       <= 5'h00;
		conv_cnt      <= 24'h000000;
		conv_busy_out <= 1'b0;
		temp          <= 11'h000;
	end
	else if (shutdown)
	begin
		per_cnt       <= 5'h00; // see R15
		conv_cnt      <= 24'h000000;
		conv_busy_out <= 1'b0;
	end
	else
	begin
		if (tick)
		begin
			if (per_cnt + 5'h01 >= eff_period) // see R3
			begin
				per_cnt       <= 5'h00;
				conv_busy_out <= 1'b1;
				conv_cnt      <= 24'h000000;
			end
			else
				per_cnt <= per_cnt + 5'h01;
		end
		if (conv_done)
		begin
			conv_busy_out <= 1'b0; // see R6
			temp          <= temp_data_in; // see R25
		end
		else if (conv_busy_out)
			conv_cnt <= conv_cnt + 24'h000001;
	end
end

// ===========================================
// fault queue and trip state, judged only at conversion end
always @(posedge mclk_in or negedge rstn_in)
begin
	if (!rstn_in)
	begin
		fcnt <= 3'h0;
		hot  <= 1'b0;
	end
	else if (conv_done)
	begin
		if (!trip)
			fcnt <= 3'h0; // see R12
		else if (q_full)
		begin
			fcnt <= 3'h0;
			hot  <= ~hot; // see R9
		end
		else
			fcnt <= fcnt + 3'h1;
	end
end

// ===========================================
// interrupt latch; a new trip beats a read clear in the same cycle
// armed only in interrupt mode, so comparator trips leave no stale event
always @(posedge mclk_in or negedge rstn_in)
begin
	if (!rstn_in)
	begin
		int_flag <= 1'b0;
		sd_d     <= 1'b0;
	end
	else
	begin
		sd_d <= shutdown;
		if (trip_evt & cfg[`TWD_CFG_MODE])
			int_flag <= 1'b1; // see R10
		else if (rd_pulse)
			int_flag <= 1'b0; // see R10
		else if (shutdown & ~sd_d)
			int_flag <= 1'b0; // see R16
	end
end

// ===========================================
// open-drain pin: enable pulls low whenever the level should be low
always @(posedge mclk_in or negedge rstn_in)
begin
	if (!rstn_in)
	begin
		overtemp_output_out    <= 1'b0;
		overtemp_output_oe_out <= 1'b0;
	end
	else
	begin
		overtemp_output_out    <= 1'b0;
		overtemp_output_oe_out <= cfg[`TWD_CFG_POL] ? ~act : act; // see R7
	end
end

// ===========================================
// two-wire slave and register file
always @(posedge mclk_in or negedge rstn_in)
begin
	if (!rstn_in)
	begin
		state         <= ST_IDLE;
		bitcnt        <= 4'h0;
		rx            <= 8'h00;
		tx            <= 8'h00;
		rw            <= 1'b0;
		first         <= 1'b0;
		widx          <= 1'b0;
		ridx          <= 1'b0;
		ack_ok        <= 1'b0;
		rd_pulse      <= 1'b0;
		tout_cnt      <= 24'h000000;
		sda_out       <= 1'b0;
		sda_oe_out    <= 1'b0;
		cfg           <= `TWD_RST_CONFIG; // see R17
		sample_period <= `TWD_RST_PERIOD; // see R5
		tos           <= `TWD_RST_TOS;
		thyst         <= `TWD_RST_THYST;
		ptr           <= `TWD_RST_PTR;
	end
	else
	begin
		rd_pulse <= 1'b0;
		// time-out: a stuck low clock mid-transfer frees the bus
		if (state == ST_IDLE || scl_s2)
			tout_cnt <= 24'h000000;
		else
			tout_cnt <= tout_cnt + 24'h000001;
		if (bus_start)
		begin
			state      <= ST_ADDR; // see R19
			bitcnt     <= 4'h0;
			sda_oe_out <= 1'b0;
			first      <= 1'b1;
		end
		else if (bus_stop || tout_cnt == TOUT_CYCLES - 1)
		begin
			state      <= ST_IDLE;
			sda_oe_out <= 1'b0;
		end
		else
		begin
			case (state)
				ST_IDLE:
					sda_oe_out <= 1'b0;
				ST_ADDR:
					if (scl_rise)
					begin
						rx     <= {rx[6:0], sda_s2};
						bitcnt <= bitcnt + 4'h1;
					end
					else if (scl_fall && bitcnt == `TWD_BYTE_BITS) // see R18
					begin
						if (rx[7:1] == DEV_ADDR)
						begin
							sda_oe_out <= 1'b1; // see R20
							rw         <= rx[0];
							state      <= ST_AACK;
						end
						else
							state <= ST_IDLE;
					end
				ST_AACK:
					if (scl_fall)
					begin
						bitcnt <= (rw) ? 4'h1 : 4'h0;
						if (rw)
						begin
							tx         <= rd_head;
							sda_oe_out <= ~rd_head[7];
							ridx       <= 1'b1;
							rd_pulse   <= 1'b1; // see R10
							state      <= ST_RD;
						end
						else
						begin
							sda_oe_out <= 1'b0;
							widx       <= 1'b0;
							state      <= ST_WR;
						end
					end
				ST_WR:
					if (scl_rise)
					begin
						rx     <= {rx[6:0], sda_s2};
						bitcnt <= bitcnt + 4'h1;
					end
					else if (scl_fall && bitcnt == `TWD_BYTE_BITS)
					begin
						sda_oe_out <= 1'b1; // see R20
						state      <= ST_WACK;
						if (first)
						begin
							ptr   <= rx[2:0];
							first <= 1'b0;
						end
						else
						begin
							widx <= ~widx;
							case (ptr)
								`TWD_PTR_CONFIG: cfg <= rx[4:0]; // see R14
								`TWD_PTR_PERIOD: sample_period <= rx[4:0]; // see R1, R2
								`TWD_PTR_TOS:
									if (widx)
										tos[0] <= rx[7];
									else
										tos[8:1] <= rx; // see R24
								`TWD_PTR_THYST:
									if (widx)
										thyst[0] <= rx[7];
									else
										thyst[8:1] <= rx; // see R24
								default: ;
							endcase
						end
					end
				ST_WACK:
					if (scl_fall)
					begin
						sda_oe_out <= 1'b0;
						bitcnt     <= 4'h0;
						state      <= ST_WR;
					end
				ST_RD:
					if (scl_fall)
					begin
						if (bitcnt == `TWD_BYTE_BITS)
						begin
							sda_oe_out <= 1'b0; // release for host acknowledge
							state      <= ST_RACK;
						end
						else
						begin
							sda_oe_out <= ~tx[6];
							tx         <= {tx[6:0], 1'b0};
							bitcnt     <= bitcnt + 4'h1;
						end
					end
				ST_RACK:
					if (scl_rise)
						ack_ok <= ~sda_s2;
					else if (scl_fall)
					begin
						if (ack_ok)
						begin
							tx         <= rd_next; // see R21
							sda_oe_out <= ~rd_next[7];
							ridx       <= ~ridx;
							bitcnt     <= 4'h1;
							state      <= ST_RD;
						end
						else
							state <= ST_IDLE; // see R22
					end
				default:
					state <= ST_IDLE;
			endcase
		end
	end
end

endmodule // twd_thermal_watchdog

/* File: twd_checker_sva.sv */
// assertion checker for the thermal watchdog control block
`timescale 1ns/100ps
module twd_checker
#(
	parameter TICK_CYCLES = 50,
	parameter CONV_CYCLES = 14
)
(
	input wire        mclk_in,
	input wire        rstn_in,
	input wire        scl_in,
	input wire        sda_in,
	input wire        sda_out,
	input wire        sda_oe_out,
	input wire [10:0] temp_data_in,
	input wire        conv_busy_out,
	input wire        overtemp_output_out,
	input wire        overtemp_output_oe_out
);
	int   busy_cnt, gap, scl_cnt;
	logic busy_q, scl_q, started;
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (!rstn_in);
	// ========
	// counters: conversion length, start spacing, cycles since bus clock moved
	always @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			busy_cnt <= 0;
			gap      <= 0;
			scl_cnt  <= 0;
			busy_q   <= 1'b0;
			scl_q    <= 1'b1;
			started  <= 1'b0;
		end
		else
		begin
			busy_cnt <= conv_busy_out ? busy_cnt + 1 : 0;
			gap      <= (conv_busy_out && !busy_q) ? 1 : gap + 1;
			scl_cnt  <= (scl_in != scl_q) ? 0 : scl_cnt + 1;
			busy_q   <= conv_busy_out;
			scl_q    <= scl_in;
			started  <= started | conv_busy_out;
		end
	end
	property p_ack_low;
		sda_out == 1'b0;
	endproperty
	a_ack_low: assert property (p_ack_low) else $error("data value not low");
	property p_pin_low;
		overtemp_output_out == 1'b0;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("trip value not low");
	property p_conv_len;
		busy_cnt <= CONV_CYCLES;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion too long");
	// first start after reset has no predecessor, so it is skipped
	property p_spacing;
		$rose(conv_busy_out) && started |-> gap >= TICK_CYCLES;
	endproperty
	a_spacing: assert property (p_spacing) else $error("starts too close");
	property p_idle;
		$fell(conv_busy_out) |-> !conv_busy_out [*8];
	endproperty
	a_idle: assert property (p_idle) else $error("no idle after conversion");
	property p_sda_edge;
		$changed(sda_oe_out) |-> !scl_in && !$past(scl_in);
	endproperty
	a_sda_edge: assert property (p_sda_edge) else $error("data moved, clock high");
	property p_trip_cause;
		$changed(overtemp_output_oe_out) |-> scl_cnt < 16
			|| ($past(conv_busy_out, 2) && !$past(conv_busy_out));
	endproperty
	a_trip_cause: assert property (p_trip_cause) else $error("trip pin moved");
	property p_rst_quiet;
		$rose(rstn_in) |-> !sda_oe_out [*3];
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("bus driven at reset");
endmodule // twd_checker
bind twd_thermal_watchdog twd_checker #(.TICK_CYCLES(TICK_CYCLES), .CONV_CYCLES(CONV_CYCLES))
	i_chk (.mclk_in(mclk_in), .rstn_in(rstn_in), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe_out(sda_oe_out), .temp_data_in(temp_data_in),
	.conv_busy_out(conv_busy_out), .overtemp_output_out(overtemp_output_out),
	.overtemp_output_oe_out(overtemp_output_oe_out));

/* File: twd_host_model.sv */
// two-wire bus host model, 800 ns bus clock, open-drain data
`timescale 1ns/100ps
module twd_host_model
(
	// bus pins
	output logic scl_out,
	output logic sda_oe_out,
	input  wire  sda_in
);
	// ========
	// bus clock rests high between frames
	initial
	begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end
	// odd offset keeps bus edges away from the system clock edges
	task automatic start;
		#7;
		sda_oe_out = 1'b0;
		// wait out the slave's late acknowledge release before clock rises
		#400;
		scl_out = 1'b1;
		#300;
		sda_oe_out = 1'b1;
		#300;
		scl_out = 1'b0;
	endtask
	task automatic stop;
		#100;
		sda_oe_out = 1'b1;
		#300;
		scl_out = 1'b1;
		#300;
		sda_oe_out = 0;
		#300;
	endtask
	// long low half leaves room for the slave's synchroniser delay
	task automatic bit_io(input logic b, output logic r);
		#100;
		sda_oe_out = ~b;
		#400;
		scl_out = 1'b1;
		#150;
		r = sda_in;
		#150;
		scl_out = 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, ack);
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule // twd_host_model

/* File: tb.sv */
// self-checking bench of the thermal watchdog control block
`timescale 1ns/100ps
module tb;
	localparam logic [6:0] ADDR = 7'h30; // arbitrary bus address
	logic        mclk = 1'b0;
	logic        rstn = 1'b0;
	logic        scl, hoe, ack, sda_oe, sda_o, busy, os, os_oe;
	logic [10:0] temp = 11'h0C8;
	logic [7:0]  b0, b1;
	wire         sda = ~sda_oe & ~hoe;
	int          n_fail = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          nconv = 0;
	int          t0;
	int          q[4] = '{1, 2, 4, 6};
	twd_thermal_watchdog #(.DEV_ADDR(ADDR), .TICK_CYCLES(50), .CONV_CYCLES(14),
		.TOUT_CYCLES(2000)) i_dut (.mclk_in(mclk), .rstn_in(rstn), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe), .temp_data_in(temp),
		.conv_busy_out(busy), .overtemp_output_out(os), .overtemp_output_oe_out(os_oe));
	twd_host_model i_host (.scl_out(scl), .sda_oe_out(hoe), .sda_in(sda));
	// ========
	// clock, cycle count with hang ceiling, conversion count
	initial
	begin
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_fail++;
			report_and_stop;
		end
	end
	always @(posedge busy) nconv++;
	task automatic report_and_stop;
		if (n_fail == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic pin(input logic e);
		chk(8'(os_oe), 8'(e));
	endtask
	task automatic conv(input int n);
		repeat (n) @(negedge busy);
		repeat (3) @(negedge mclk);
	endtask
	task automatic period(input int e);
		@(posedge busy);
		t0 = cyc;
		@(posedge busy);
		chk(8'(cyc - t0), 8'(e));
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		i_host.start;
		i_host.wbyte({ADDR, 1'b0}, ack);
		chk(8'(ack), 8'h00);
		i_host.wbyte(p, ack);
		i_host.wbyte(d, ack);
		i_host.stop;
	endtask
	// pointer FF skips the pointer write and reads from the current pointer
	task automatic rd(input logic [7:0] p, input int n);
		i_host.start;
		if (p != 8'hFF)
		begin
			i_host.wbyte({ADDR, 1'b0}, ack);
			i_host.wbyte(p, ack);
			i_host.start;
		end
		i_host.wbyte({ADDR, 1'b1}, ack);
		chk(8'(ack), 8'h00);
		i_host.rbyte(n == 1, b0);
		if (n > 1)
			i_host.rbyte(1'b1, b1);
		i_host.stop;
	endtask
	// ========
	// main sequence; default limits 80 over 75 kept ordered throughout
	initial
	begin
		repeat (8) @(negedge mclk);
		rstn = 1'b1;
		repeat (100) @(negedge mclk);
		pin(1'b0);
		rd(8'hFF, 2);
		chk(b0, 8'h19);
		chk(b1, 8'h00);
		rd(8'h04, 1);
		chk(b0, 8'h01);
		rd(8'h01, 1);
		chk(b0, 8'h00);
		rd(8'h03, 2);
		chk(b0, 8'h50);
		chk(b1, 8'h00);
		rd(8'h02, 1);
		chk(b0, 8'h4B);
		wr(8'h04, 8'hE3);
		rd(8'h04, 1);
		chk(b0, 8'h03);
		period(150);
		wr(8'h04, 8'h00);
		period(50);
		temp = 11'h3F1;
		conv(1);
		pin(1'b1);
		rd(8'h00, 2);
		chk(b0, 8'h7E);
		chk(b1, 8'h20);
		pin(1'b1);
		wr(8'h01, 8'h01);
		pin(1'b1);
		t0 = nconv;
		repeat (300) @(negedge mclk);
		chk(8'(nconv - t0), 8'h00);
		rd(8'h01, 1);
		chk(b0, 8'h01);
		temp = 11'h000;
		wr(8'h01, 8'h04);
		conv(2);
		pin(1'b1);
		temp = 11'h3F8;
		conv(1);
		pin(1'b0);
		i_host.start;
		i_host.wbyte({7'h31, 1'b0}, ack);
		i_host.stop;
		chk(8'(ack), 8'h01);
		for (int c = 0; c < 4; c++)
		begin
			temp = 11'h000;
			conv(6);
			wr(8'h01, {3'h0, 2'(c), 3'h0});
			conv(1);
			temp = 11'h3F8;
			conv(q[c] - 1);
			pin(1'b0);
			conv(1);
			pin(1'b1);
		end
		temp = 11'h000;
		conv(6);
		wr(8'h01, 8'h02);
		pin(1'b0);
		conv(1);
		temp = 11'h3F8;
		conv(1);
		pin(1'b1);
		conv(2);
		pin(1'b1);
		rd(8'h01, 1);
		chk(b0, 8'h02);
		pin(1'b0);
		temp = 11'h000;
		conv(1);
		pin(1'b1);
		wr(8'h01, 8'h03);
		pin(1'b0);
		report_and_stop;
	end
endmodule // tb
